// file: hdl/ivm_top.sv
// How it works
// - vectors 0..255, table offset is 0x3fc minus four times number; 66+ trap only
// - fetch address is base 0x000ffc00 plus the table offset
// - non-maskable vector 15 at fixed level 15 from four error sources
// - exceptions on vectors 5 to 8 carry no programmable level
// - external inputs 0-7 on vector 16; 8-15 and low voltage on 17
// - vectors 16..63 each have one level, sources on one vector are merged
// - all dma completions on vector 62, delay on 63, neither has resource
// - sources without resource number never request dma
// - dma resource number is vector number minus 16
// - serial status and two-wire reception never start dma
// - reload timer channels 4 to 7 never start dma
// - pulse_generator channels 24 to 47 never start dma
// - clock calibration interrupts never start dma
// - 32-bit free-run timer channels 3 to 5 never start dma
// - low voltage detection never starts dma
// - vectors 34 to 37 have no resource number
// - vector 60 has no source, never raised by hardware
`timescale 1ns/1ps
`default_nettype none
module ivm_top
(
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire ivm_pkg::ivm_src_type      periphSrc,
    input  wire logic [15:0]               dmaChanDone,
    input  wire logic                      delayEvent,
    input  wire ivm_pkg::ivm_level_type    levelRegVector,
    input  wire logic [3:0]                nmiSrc,
    input  wire logic [3:0]                excSrc,
    input  wire ivm_pkg::ivm_trap_req_type trapReq,
    output ivm_pkg::ivm_core_req_type      coreReq,
    output logic [47:0]                    dmaReq,
    output ivm_pkg::ivm_trap_ans_type      trapAns
);
    logic [47:0]               vecReq;
    logic [47:0]               dmaOk;
    logic                      selValid;
    logic [5:0]                selIdx;
    logic [3:0]                selLevel;
    ivm_pkg::ivm_core_req_type coreReq_d;
    ivm_pkg::ivm_core_req_type coreReq_q;
    ivm_pkg::ivm_trap_ans_type trapAns_d;
    ivm_pkg::ivm_trap_ans_type trapAns_q;
    logic [47:0]               dmaReq_d;
    logic [47:0]               dmaReq_q;
    logic [47:0]               rnMask;

    // source merging and dma qualification
    ivm_merge uMerge
    (
        .clk         (clk),
        .srst        (srst),
        .periphSrc   (periphSrc),
        .dmaChanDone (dmaChanDone),
        .delayEvent  (delayEvent),
        .vecReq      (vecReq),
        .dmaOk       (dmaOk)
    );

    // maskable priority selection
    ivm_arbiter uArb
    (
        .clk      (clk),
        .srst     (srst),
        .vecReq   (vecReq),
        .levels   (levelRegVector),
        .selValid (selValid),
        .selIdx   (selIdx),
        .selLevel (selLevel)
    );

    // vectors that own a resource number at all
    for (genvar v = 0; v < ivm_pkg::NUM_MASKABLE; v++)
    begin : gRn
        assign rnMask[v] = |ivm_pkg::SLOT_DMA[v];
    end

    // core request: exceptions, then nmi, then maskable
    always_comb
    begin
        logic [7:0] excNum;
        excNum    = ivm_pkg::VEC_EXC_FIRST;
        coreReq_d = '0;
        for (int i = 3; i >= 0; i--)
        begin
            if (excSrc[i])
            begin
                excNum = ivm_pkg::VEC_EXC_FIRST + 8'(i);
            end
        end
        if (|excSrc)
        begin
            coreReq_d.valid      = 1'b1;
            coreReq_d.fixedLevel = 1'b1;
            coreReq_d.vector     = excNum;
            coreReq_d.level      = ivm_pkg::LEVEL_OFF;
        end
        else if (|nmiSrc)
        begin
            coreReq_d.valid      = 1'b1;
            coreReq_d.fixedLevel = 1'b1;
            coreReq_d.vector     = ivm_pkg::VEC_NMI;
            coreReq_d.level      = ivm_pkg::NMI_LEVEL;
        end
        else if (selValid)
        begin
            coreReq_d.valid      = 1'b1;
            coreReq_d.vector     = ivm_pkg::VEC_MASK_FIRST + {2'b00, selIdx};
            coreReq_d.level      = selLevel;
        end
        coreReq_d.fetchAddr = ivm_pkg::vec_addr(coreReq_d.vector);
    end

    // dma requests indexed by resource number
    always_comb
    begin
        dmaReq_d = dmaOk & rnMask;
    end

    // software trap resolution for any number
    always_comb
    begin
        trapAns_d           = '0;
        trapAns_d.ack       = trapReq.valid;
        trapAns_d.number    = trapReq.number;
        trapAns_d.fetchAddr = ivm_pkg::vec_addr(trapReq.number);
    end

    // registered outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            coreReq_q <= '0;
            trapAns_q <= '0;
            dmaReq_q  <= '0;
        end
        else
        begin
            coreReq_q <= coreReq_d;
            trapAns_q <= trapAns_d;
            dmaReq_q  <= dmaReq_d;
        end
    end

    assign coreReq = coreReq_q;
    assign trapAns = trapAns_q;
    assign dmaReq  = dmaReq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence sExc;
        |excSrc;
    endsequence

    sequence sNmiOnly;
        !(|excSrc) && (|nmiSrc);
    endsequence

    sequence sMaskOnly;
        !(|excSrc) && !(|nmiSrc) && selValid;
    endsequence

    sequence sTrap(logic [7:0] n);
        trapReq.valid && trapReq.number == n;
    endsequence

    AST_TABLE_OFS: assert property (trapReq.valid |=> trapAns_q.ack
        && trapAns_q.fetchAddr == 32'h000ffc00 + 32'h3fc
        - {22'h0, $past(trapReq.number), 2'b00})
        else $error("trap fetch address not table offset");

    AST_TOP_ENTRY: assert property (sTrap(8'hff) |=>
        trapAns_q.fetchAddr == 32'h000ffc00)
        else $error("vector 255 not at offset zero");

    AST_TRAP_ONLY: assert property (coreReq_q.valid |->
        coreReq_q.vector < 8'h42)
        else $error("hardware raised a trap only vector");

    AST_INVALID_INSN: assert property (sTrap(8'h0e) |=>
        trapAns_q.fetchAddr == 32'h000fffc4)
        else $error("vector 14 fetch address wrong");

    AST_CORE_ADDR: assert property (coreReq_q.valid |->
        coreReq_q.fetchAddr[31:10] == 22'h0003ff
        && coreReq_q.fetchAddr[9:2] == ~coreReq_q.vector)
        else $error("core fetch address wrong");

    AST_NMI_FIXED: assert property (sNmiOnly |=> coreReq_q.valid
        && coreReq_q.vector == 8'h0f && coreReq_q.level == 4'hf
        && coreReq_q.fixedLevel)
        else $error("nmi not on vector 15 at level 15");

    AST_EXC_FIRST: assert property (sExc ##0 excSrc[0] |=>
        coreReq_q.vector == 8'h05 && coreReq_q.fixedLevel)
        else $error("lowest exception not on vector 5");

    AST_EXC_LAST: assert property (excSrc == 4'h8 |=>
        coreReq_q.vector == 8'h08 && coreReq_q.fixedLevel)
        else $error("data access error not on vector 8");

    AST_EXT_VEC: assert property (sMaskOnly ##0 selIdx == 6'h01 |=>
        coreReq_q.vector == 8'h11 && coreReq_q.level == $past(levelRegVector[1]))
        else $error("vector 17 level not its own");

    AST_MASK_VEC: assert property (sMaskOnly |=> !coreReq_q.fixedLevel
        && coreReq_q.vector == 8'h10 + {2'b00, $past(selIdx)})
        else $error("maskable vector number wrong");

    AST_DMA_NONE: assert property (|dmaChanDone || delayEvent |=>
        !dmaReq_q[46] && !dmaReq_q[47])
        else $error("dma completion or delay requested dma");

    AST_NO_RN: assert property ((dmaReq_q & ~rnMask) == 48'h0)
        else $error("dma request without resource number");

    AST_RN_INDEX: assert property (periphSrc[29][0] |=> dmaReq_q[29])
        else $error("vector 45 not on resource 29");

    AST_SERIAL_STATUS: assert property (periphSrc[4] == 8'h02 |=>
        !dmaReq_q[4])
        else $error("serial status started dma");

    AST_RELOAD_HIGH: assert property (periphSrc[2] == 8'h0c |=>
        !dmaReq_q[2])
        else $error("reload timer 4-7 started dma");

    AST_RELOAD_LOW: assert property (periphSrc[2] == 8'h01 |=>
        dmaReq_q[2])
        else $error("reload timer 0 lost dma");

    AST_PPG_HIGH: assert property (periphSrc[24] == 8'h02 |=>
        !dmaReq_q[24])
        else $error("high pulse_generator channels started dma");

    AST_PPG_LOW: assert property (periphSrc[24] == 8'h01 |=>
        dmaReq_q[24])
        else $error("low pulse_generator channels lost dma");

    AST_CAL_SUB: assert property (periphSrc[31] == 8'h02 |=>
        !dmaReq_q[31])
        else $error("sub calibration started dma");

    AST_CAL_RC: assert property (periphSrc[32] == 8'h04 |=>
        !dmaReq_q[32])
        else $error("rc calibration started dma");

    AST_FREE_RUN: assert property (periphSrc[34] == 8'h01 |=>
        !dmaReq_q[34])
        else $error("free-run timer 4 started dma");

    AST_FREE_RUN_B: assert property (|periphSrc[35]
        && (periphSrc[35] & 8'h04) == 8'h00 |=> !dmaReq_q[35])
        else $error("free-run timer 3 or 5 started dma");

    AST_LOW_VOLT: assert property (periphSrc[1] == 8'h02 |=>
        !dmaReq_q[1])
        else $error("low voltage started dma");

    AST_NO_RN_VEC: assert property (dmaReq_q[21:18] == 4'h0)
        else $error("vectors 34-37 requested dma");

    AST_VEC60: assert property (coreReq_q.valid |->
        coreReq_q.vector != 8'h3c)
        else $error("vector 60 presented");

    AST_PRIO_OUT: assert property (sMaskOnly |=>
        coreReq_q.level == $past(selLevel) && coreReq_q.valid)
        else $error("selected maskable not presented");
endmodule // ivm_top
`default_nettype wire

// file: hdl/ivm_pkg.sv
`default_nettype none
package ivm_pkg;
    // vector numbering
    localparam int          NUM_MASKABLE   = 48;
    localparam int          SLOTS          = 8;
    localparam logic [7:0]  VEC_MASK_FIRST = 8'h10;
    localparam logic [7:0]  VEC_EXC_FIRST  = 8'h05;
    localparam logic [7:0]  VEC_NMI        = 8'h0f;
    localparam logic [7:0]  VEC_TRAP_FIRST = 8'h42;
    localparam logic [3:0]  NMI_LEVEL      = 4'hf;
    localparam logic [3:0]  LEVEL_OFF      = 4'h0;
    localparam int          IDX_DMA_DONE   = 46;
    localparam int          IDX_DELAY      = 47;
    localparam int          IDX_NO_SOURCE  = 44;

    // vector table placement
    localparam logic [31:0] TABLE_BASE     = 32'h000ffc00;
    localparam logic [31:0] TABLE_TOP_OFS  = 32'h000003fc;

    // peripheral slots wired per vector, vectors 16..63 in order
    localparam logic [7:0]  SLOT_USED [NUM_MASKABLE] = '{
        8'h01, 8'h03, 8'h0f, 8'h0f, 8'h03, 8'h01, 8'h03, 8'h01,
        8'h03, 8'h01, 8'h03, 8'h01, 8'h03, 8'h01, 8'h03, 8'h01,
        8'h03, 8'h01, 8'h01, 8'h7f, 8'h07, 8'h01, 8'h03, 8'h03,
        8'h07, 8'h07, 8'h03, 8'h03, 8'h03, 8'h07, 8'h0f, 8'h07,
        8'h07, 8'h03, 8'h03, 8'h07, 8'h07, 8'h03, 8'h07, 8'h07,
        8'h07, 8'h03, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00};

    // slots allowed to start a dma transfer, same order
    localparam logic [7:0]  SLOT_DMA [NUM_MASKABLE] = '{
        8'h01, 8'h01, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
        8'h05, 8'h05, 8'h01, 8'h01, 8'h01, 8'h05, 8'h0f, 8'h05,
        8'h02, 8'h03, 8'h02, 8'h04, 8'h03, 8'h03, 8'h03, 8'h07,
        8'h07, 8'h03, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00};

    typedef logic [NUM_MASKABLE-1:0][SLOTS-1:0] ivm_src_type;
    typedef logic [NUM_MASKABLE-1:0][3:0]       ivm_level_type;

    typedef struct packed {
        logic        valid;
        logic        fixedLevel;
        logic [7:0]  vector;
        logic [3:0]  level;
        logic [31:0] fetchAddr;
    } ivm_core_req_type;

    typedef struct packed {
        logic        valid;
        logic [7:0]  number;
    } ivm_trap_req_type;

    typedef struct packed {
        logic        ack;
        logic [7:0]  number;
        logic [31:0] fetchAddr;
    } ivm_trap_ans_type;

    // default fetch address of a vector number
    function automatic logic [31:0] vec_addr(input logic [7:0] num);
        return TABLE_BASE + (TABLE_TOP_OFS - {22'h0, num, 2'b00});
    endfunction
endpackage
`default_nettype wire

// file: hdl/ivm_merge.sv
`timescale 1ns/1ps
`default_nettype none
module ivm_merge
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire ivm_pkg::ivm_src_type periphSrc,
    input  wire logic [15:0]         dmaChanDone,
    input  wire logic                delayEvent,
    output logic [47:0]              vecReq,
    output logic [47:0]              dmaOk
);
    logic [47:0] rawReq;
    logic [47:0] extraReq;

    // per vector or of wired slots, and of dma capable slots
    for (genvar v = 0; v < ivm_pkg::NUM_MASKABLE; v++)
    begin : gVec
        assign rawReq[v] = |(periphSrc[v] & ivm_pkg::SLOT_USED[v]);
        assign dmaOk[v]  = |(periphSrc[v] & ivm_pkg::SLOT_DMA[v]);
    end

    // all dma completions onto one vector, delay onto the next
    assign extraReq = (48'(|dmaChanDone) << ivm_pkg::IDX_DMA_DONE)
                    | (48'(delayEvent) << ivm_pkg::IDX_DELAY);
    assign vecReq   = rawReq | extraReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_EXT_LOW: assert property (periphSrc[0][0] |-> vecReq[0])
        else $error("external inputs 0-7 not on vector 16");
    AST_EXT_SHARE: assert property (periphSrc[1] == 8'h02 |-> vecReq[1] && !dmaOk[1])
        else $error("low voltage not merged on vector 17");
    AST_MERGE: assert property (periphSrc[30][3] && periphSrc[30][0] |-> vecReq[30])
        else $error("shared sources not merged");
    AST_DMA_DONE: assert property (dmaChanDone[15] |-> vecReq[46] && !dmaOk[46])
        else $error("dma completion mapping wrong");
    AST_DELAY: assert property (delayEvent |-> vecReq[47] && !dmaOk[47])
        else $error("delay interrupt mapping wrong");
    AST_NO_SOURCE: assert property (!vecReq[44])
        else $error("vector 60 raised by hardware");
endmodule // ivm_merge
`default_nettype wire

// file: hdl/ivm_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module ivm_arbiter
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic [47:0]           vecReq,
    input  wire ivm_pkg::ivm_level_type levels,
    output logic                       selValid,
    output logic [5:0]                 selIdx,
    output logic [3:0]                 selLevel
);
    // highest level wins, walk down so lower vector wins a tie
    always_comb
    begin
        selValid = 1'b0;
        selIdx   = 6'h00;
        selLevel = ivm_pkg::LEVEL_OFF;
        for (int i = ivm_pkg::NUM_MASKABLE - 1; i >= 0; i--)
        begin
            if (vecReq[i] && levels[i] != ivm_pkg::LEVEL_OFF && levels[i] >= selLevel)
            begin
                selValid = 1'b1;
                selIdx   = 6'(i);
                selLevel = levels[i];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    for (genvar j = 0; j < ivm_pkg::NUM_MASKABLE; j++)
    begin : gChk
        AST_PRIO: assert property (
            vecReq[j] && levels[j] != 4'h0 |-> selValid && (levels[j] < selLevel
            || (levels[j] == selLevel && 6'(j) >= selIdx)))
            else $error("pending request beaten by lower priority");
    end
endmodule // ivm_arbiter
`default_nettype wire

// file: verif/ivm_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// peripheral side: only slots that are wired can ever raise a request
module ivm_periph_model
(
    input  wire ivm_pkg::ivm_src_type rawSrc,
    output var  ivm_pkg::ivm_src_type periphSrc
);
    // unwired slots and the empty vector 60 stay low
    always_comb
    begin
        for (int i = 0; i < ivm_pkg::NUM_MASKABLE; i++)
        begin
            periphSrc[i] = rawSrc[i] & ivm_pkg::SLOT_USED[i];
        end
    end
endmodule // ivm_periph_model
`default_nettype wire

// file: verif/test_interrupt_vector_and_dma_map.sv
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_vector_and_dma_map;
    // slots that may start a transfer, vectors 16..63
    localparam logic [7:0] DMA_OK [48] = '{
        8'h01, 8'h01, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
        8'h05, 8'h05, 8'h01, 8'h01, 8'h01, 8'h05, 8'h0f, 8'h05,
        8'h02, 8'h03, 8'h02, 8'h04, 8'h03, 8'h03, 8'h03, 8'h07,
        8'h07, 8'h03, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00};
    localparam int TRAP_NUMS [6] = '{0, 14, 15, 65, 66, 255};

    logic                      clk;
    logic                      srst;
    ivm_pkg::ivm_src_type      rawSrc;
    ivm_pkg::ivm_src_type      periphSrc;
    logic [15:0]               dmaChanDone;
    logic                      delayEvent;
    ivm_pkg::ivm_level_type    levelRegVector;
    logic [3:0]                nmiSrc;
    logic [3:0]                excSrc;
    ivm_pkg::ivm_trap_req_type trapReq;
    ivm_pkg::ivm_core_req_type coreReq;
    logic [47:0]               dmaReq;
    ivm_pkg::ivm_trap_ans_type trapAns;
    logic [31:0]               seed;
    int                        badCount;
    int                        numChecks;

    ivm_periph_model u_periph
    (
        .rawSrc    (rawSrc),
        .periphSrc (periphSrc)
    );

    ivm_top u_dut
    (
        .clk            (clk),
        .srst           (srst),
        .periphSrc      (periphSrc),
        .dmaChanDone    (dmaChanDone),
        .delayEvent     (delayEvent),
        .levelRegVector (levelRegVector),
        .nmiSrc         (nmiSrc),
        .excSrc         (excSrc),
        .trapReq        (trapReq),
        .coreReq        (coreReq),
        .dmaReq         (dmaReq),
        .trapAns        (trapAns)
    );

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // base plus offset from the top of the table
    function automatic logic [31:0] addr_of(input int n);
        return 32'h000ffc00 + 32'h000003fc - 32'(4 * n);
    endfunction

    // one comparison
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // all inputs quiet
    task automatic clear_in();
        rawSrc = '0;
        dmaChanDone = 16'h0000;
        delayEvent = 1'b0;
        levelRegVector = '0;
        nmiSrc = 4'h0;
        excSrc = 4'h0;
        trapReq = '0;
    endtask

    // predict from inputs in force, compare one cycle later
    task automatic step();
        logic [47:0] req;
        logic [47:0] expDma;
        logic [47:0] nz;
        logic        eValid;
        logic        eFix;
        int          eVec;
        logic [3:0]  eLev;
        logic        eAck;
        logic [7:0]  eNum;
        #1;
        eValid = 1'b0;
        eFix = 1'b1;
        eVec = 0;
        eLev = 4'h0;
        for (int i = 0; i < 48; i++)
        begin
            req[i] = |periphSrc[i];
            expDma[i] = |(periphSrc[i] & DMA_OK[i]);
            nz[i] = levelRegVector[i] != 4'h0;
        end
        req[46] = |dmaChanDone;
        req[47] = delayEvent;
        for (int i = 3; i >= 0; i--)
        begin
            if (excSrc[i])
            begin
                eValid = 1'b1;
                eVec = 5 + i;
            end
        end
        if (!eValid && |nmiSrc)
        begin
            eValid = 1'b1;
            eVec = 15;
            eLev = 4'hf;
        end
        if (!eValid)
        begin
            eFix = 1'b0;
            for (int i = 47; i >= 0; i--)
            begin
                if (req[i] && nz[i] && levelRegVector[i] >= eLev)
                begin
                    eValid = 1'b1;
                    eVec = 16 + i;
                    eLev = levelRegVector[i];
                end
            end
        end
        eAck = trapReq.valid && !srst;
        eNum = trapReq.number;
        if (srst)
        begin
            eValid = 1'b0;
            expDma = '0;
        end
        @(negedge clk);
        chk(64'(coreReq.valid), 64'(eValid));
        if (eValid)
        begin
            chk({coreReq.fixedLevel, coreReq.level, coreReq.vector}, {eFix, eLev, 8'(eVec)});
            chk(coreReq.fetchAddr, addr_of(eVec));
        end
        chk(64'(dmaReq), 64'(expDma));
        chk(64'(trapAns.ack), 64'(eAck));
        if (eAck)
        begin
            chk({trapAns.number, trapAns.fetchAddr}, {eNum, addr_of(eNum)});
        end
    endtask

    // verdict
    task automatic tally_and_finish();
        if (badCount == 0 && numChecks > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // main sequence
    initial
    begin
        logic [31:0] r;
        seed = 32'h87e3ec8c;
        badCount = 0;
        numChecks = 0;
        srst = 1'b1;
        clear_in();
        repeat (15) @(negedge clk);
        step();
        srst = 1'b0;
        // vector 45 at level 3
        rawSrc[29] = 8'h01;
        levelRegVector[29] = 4'h3;
        step();
        // each slot alone, covers every dma refusal
        for (int v = 0; v < 48; v++)
        begin
            for (int s = 0; s < 8; s++)
            begin
                clear_in();
                levelRegVector[v] = 4'h1;
                rawSrc[v][s] = 1'b1;
                step();
            end
        end
        // completions and delay tie at one level
        clear_in();
        levelRegVector[46] = 4'h2;
        levelRegVector[47] = 4'h2;
        dmaChanDone = 16'h8000;
        delayEvent = 1'b1;
        step();
        // exceptions over the non-maskable over maskable
        rawSrc[0] = 8'h01;
        levelRegVector[0] = 4'hf;
        nmiSrc = 4'h8;
        excSrc = 4'ha;
        step();
        excSrc = 4'h0;
        step();
        // trap lookups back to back
        for (int k = 0; k < 6; k++)
        begin
            trapReq = {1'b1, 8'(TRAP_NUMS[k])};
            step();
        end
        // random traffic, one reset in mid-run
        for (int k = 0; k < 400; k++)
        begin
            for (int i = 0; i < 48; i++)
            begin
                r = xs();
                rawSrc[i] = r[11:4] & r[19:12] & r[27:20];
                levelRegVector[i] = r[3:0];
            end
            r = xs();
            dmaChanDone = (r[31:28] == 4'h0) ? r[15:0] : 16'h0000;
            delayEvent = r[16] & r[17];
            nmiSrc = (r[27:24] == 4'h0) ? r[21:18] : 4'h0;
            excSrc = (r[27:23] == 5'h00) ? r[3:0] : 4'h0;
            trapReq = {r[29], r[11:4]};
            srst = (k == 200);
            step();
        end
        tally_and_finish();
    end
endmodule // test_interrupt_vector_and_dma_map
`default_nettype wire
